/* File: hdl/flash_self_program_control.sv */
// Flash self-program controller: APB registers, page buffer, op timing
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Store-ready interrupt while enabled, global enable set and self-program off.
// - No store-ready interrupt while eeprom write or flash operation runs.
// - Section busy bit always reads zero.
// - Reserved bit five always reads zero.
// - Writing section read enable during buffer fill clears the whole buffer.
// - Load within three cycles of arming returns fuse or lock byte.
// - Page write armed; next store within four cycles writes buffer to page.
// - Page write bit clears at completion or when no store comes in time.
// - Core stalled for the whole page write or page erase.
// - Page erase armed; next store within four cycles erases pointer's page.
// - Page erase bit clears at completion or when no store comes in time.
// - Pointer value two in the load window returns the extended fuse byte.
// - Fuse and lock bits read zero when programmed, one when not.
// - A running flash write completes even when a core reset arrives.
// - Erase, write and lock writes take the programming time.
// - Store instructions accepted from any flash address.
module flash_self_program_control
#(
    parameter int PAGE_WORDS = 32,
    parameter int PROG_CYCLES = self_prog_pkg::PROG_CYCLES
)
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic por_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire self_prog_pkg::core_req_s core_req,
    input wire logic global_irq_enable,
    input wire logic eeprom_write_busy,
    input wire self_prog_pkg::fuse_s fuse_state,
    input wire logic [7:0] flash_rdata,
    output logic [7:0] lpm_rdata,
    output logic core_stall,
    output logic store_ready_irq,
    output logic irq,
    output var self_prog_pkg::flash_cmd_s flash_cmd
);
    localparam int WI_W = $clog2(PAGE_WORDS);
    localparam logic [31:0] LAST_CYC = 32'(PROG_CYCLES - 1);
    localparam logic [31:0] WORDS_32 = 32'(PAGE_WORDS);

    typedef enum {ST_IDLE, ST_ERASE, ST_WRITE, ST_LOCK} op_state_e;

    logic [1:0] rst_sync_r;
    logic [1:0] por_sync_r;
    logic rst_n;
    logic por_ok_n;
    logic [7:0] ctrl_r;
    logic [1:0] stat_r;
    logic [1:0] mask_r;
    logic [2:0] store_win_r;
    logic [2:0] load_win_r;
    logic [31:0] prdata_r;
    logic [7:0] lpm_rdata_r;
    logic [PAGE_WORDS-1:0] valid_r;
    logic [15:0] buf_mem [PAGE_WORDS];
    op_state_e op_state_r;
    logic [31:0] op_cnt_r;
    logic [15:0] op_ptr_r;
    self_prog_pkg::flash_cmd_s flash_cmd_r;

    ////////////////////////////////////////////////////////////////////////
    // Reset synchronisers, async assert and two-flop release
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    // Power-on reset keeps the flash engine alive across other resets
    always_ff @(posedge mclk or negedge por_n)
    begin
        if (!por_n)
            por_sync_r <= 2'h0;
        else
            por_sync_r <= {por_sync_r[0], 1'b1};
    end

    assign rst_n = rst_sync_r[1];
    assign por_ok_n = por_sync_r[1];

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    wire apb_setup = psel && !penable;
    wire apb_access = psel && penable;
    wire hit_ctrl = paddr == self_prog_pkg::CTRL_OFS;
    wire hit_stat = paddr == self_prog_pkg::STAT_OFS;
    wire hit_mask = paddr == self_prog_pkg::MASK_OFS;
    wire hit_any = hit_ctrl || hit_stat || hit_mask;
    wire ctrl_wr = apb_access && pwrite && hit_ctrl;
    wire mask_wr = apb_access && pwrite && hit_mask;
    wire stat_rd = apb_access && !pwrite && hit_stat;
    wire op_busy = op_state_r != ST_IDLE;

    // Control as read: fixed-zero bits forced low
    wire [7:0] ctrl_view = ctrl_r & self_prog_pkg::CTRL_WR_MASK;

    // Read data mux, captured in the setup cycle
    wire [31:0] rd_mux = hit_ctrl ? {24'h00_0000, ctrl_view} :
                         hit_stat ? {30'h0000_0000, stat_r} :
                         hit_mask ? {30'h0000_0000, mask_r} : 32'h0000_0000;

    // Zero-wait slave, error on unmapped address
    assign pready = 1'b1;
    assign pslverr = apb_access && !hit_any;
    assign prdata = prdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Arming and store decode
    wire arm_wr = ctrl_wr && !op_busy && pwdata[self_prog_pkg::POS_SELF_EN];
    wire arm_load = arm_wr && pwdata[self_prog_pkg::POS_LOCK_SEL] &&
                    !pwdata[self_prog_pkg::POS_PG_WRITE] &&
                    !pwdata[self_prog_pkg::POS_PG_ERASE];
    // Any fetch address may issue the store; no section check
    wire store_go = core_req.store_program_memory_instr &&
                    store_win_r != 3'h0 && !op_busy;
    wire expire = store_win_r == 3'h1 && !store_go;
    wire do_erase = ctrl_r[self_prog_pkg::POS_PG_ERASE];
    wire do_write = ctrl_r[self_prog_pkg::POS_PG_WRITE] && !do_erase;
    wire do_lock = ctrl_r[self_prog_pkg::POS_LOCK_SEL] &&
                   !do_erase && !do_write;
    wire do_clear = ctrl_r[self_prog_pkg::POS_SECT_RD_EN] &&
                    !do_erase && !do_write && !do_lock;
    wire do_load = !do_erase && !do_write && !do_lock && !do_clear;
    wire op_start = store_go && (do_erase || do_write || do_lock);
    wire op_done = op_busy && op_cnt_r == LAST_CYC;
    wire [WI_W-1:0] load_idx = core_req.pointer[WI_W:1];

    // Buffer clear: section read enable during a fill, or after a write
    wire buf_clear = (ctrl_wr && pwdata[self_prog_pkg::POS_SECT_RD_EN] &&
                      |valid_r) ||
                     (store_go && do_clear) ||
                     (op_done && op_state_r == ST_WRITE);
    wire buf_load = store_go && do_load;
    wire arm_clear = expire || op_done || (store_go && (do_load || do_clear));

    ////////////////////////////////////////////////////////////////////////
    // Control register: software write, hardware auto-clear
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_r <= self_prog_pkg::CTRL_RESET;
        else if (ctrl_wr && !op_busy)
            ctrl_r <= pwdata[7:0] & self_prog_pkg::CTRL_WR_MASK;
        else
        begin
            // Enable write while busy must not swallow the auto-clear
            if (ctrl_wr)
                ctrl_r[self_prog_pkg::POS_IRQ_EN] <=
                    pwdata[self_prog_pkg::POS_IRQ_EN];
            if (arm_clear)
                ctrl_r[4:0] <= 5'h00;
        end
    end

    // Store window opens on arming and stays open four cycles
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            store_win_r <= 3'h0;
        else if (arm_wr)
            store_win_r <= self_prog_pkg::STORE_WINDOW_CYC;
        else if (store_go)
            store_win_r <= 3'h0;
        else if (store_win_r != 3'h0)
            store_win_r <= store_win_r - 3'h1;
    end

    // Load window for fuse and lock reads
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            load_win_r <= 3'h0;
        else if (arm_load)
            load_win_r <= self_prog_pkg::LOAD_WINDOW_CYC;
        else if (load_win_r != 3'h0)
            load_win_r <= load_win_r - 3'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Event status: set wins over read-clear
    wire [1:0] ev_set = {expire, op_done};
    wire [1:0] stat_nxt = (stat_r & ~{2{stat_rd}}) | ev_set;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            stat_r <= self_prog_pkg::STAT_RESET;
        else
            stat_r <= stat_nxt;
    end

    // Mask register and read data capture
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mask_r <= self_prog_pkg::MASK_RESET;
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            if (mask_wr)
                mask_r <= pwdata[1:0];
            if (apb_setup && !pwrite)
                prdata_r <= rd_mux;
        end
    end

    assign irq = |(stat_r & mask_r);

    // Store-ready request to the core
    assign store_ready_irq = ctrl_r[self_prog_pkg::POS_IRQ_EN] &&
                             global_irq_enable &&
                             !ctrl_r[self_prog_pkg::POS_SELF_EN] &&
                             !eeprom_write_busy && !op_busy;

    ////////////////////////////////////////////////////////////////////////
    // Load path: fuse or lock byte inside the window, else flash byte
    wire [7:0] fuse_pick =
        core_req.pointer[1:0] == self_prog_pkg::SEL_LOCK ? fuse_state.lock :
        core_req.pointer[1:0] == self_prog_pkg::SEL_FUSE_EXT ?
            fuse_state.extended_fuse_byte :
        core_req.pointer[1:0] == self_prog_pkg::SEL_FUSE_HIGH ?
            fuse_state.fuse_high : fuse_state.fuse_low;
    // Stored bits pass as is: programmed reads zero
    wire [7:0] load_mux = load_win_r != 3'h0 ? fuse_pick : flash_rdata;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            lpm_rdata_r <= 8'h00;
        else if (core_req.load_program_memory_instr)
            lpm_rdata_r <= load_mux;
    end

    assign lpm_rdata = lpm_rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Page buffer valid bits, kept across core resets
    always_ff @(posedge mclk or negedge por_ok_n)
    begin
        if (!por_ok_n)
            valid_r <= '0;
        else if (buf_clear)
            valid_r <= '0;
        else if (buf_load)
            valid_r[load_idx] <= 1'b1;
    end

    // Page buffer storage
    always_ff @(posedge mclk)
    begin
        if (buf_load)
            buf_mem[load_idx] <= core_req.word;
    end

    ////////////////////////////////////////////////////////////////////////
    // Flash operation engine on power-on reset only
    always_ff @(posedge mclk or negedge por_ok_n)
    begin
        if (!por_ok_n)
        begin
            op_state_r <= ST_IDLE;
            op_cnt_r <= 32'h0000_0000;
            op_ptr_r <= 16'h0000;
        end
        else
        begin
            case (op_state_r)
                ST_IDLE:
                begin
                    op_cnt_r <= 32'h0000_0000;
                    op_ptr_r <= core_req.pointer;
                    if (op_start && do_erase)
                        op_state_r <= ST_ERASE;
                    else if (op_start && do_write)
                        op_state_r <= ST_WRITE;
                    else if (op_start)
                        op_state_r <= ST_LOCK;
                end
                default:
                begin
                    op_cnt_r <= op_cnt_r + 32'h0000_0001;
                    if (op_done)
                        op_state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Flash command: erase and lock pulses, or word writes of the page
    wire write_phase = op_state_r == ST_WRITE && op_cnt_r < WORDS_32;
    wire [WI_W-1:0] wr_idx = op_cnt_r[WI_W-1:0];
    wire [15:0] page_base = {op_ptr_r[15:WI_W+1], {(WI_W+1){1'b0}}};
    wire [15:0] wr_addr = page_base | {{(15-WI_W){1'b0}}, wr_idx, 1'b0};

    always_ff @(posedge mclk or negedge por_ok_n)
    begin
        if (!por_ok_n)
            flash_cmd_r <= '0;
        else
        begin
            flash_cmd_r <= '0;
            if (op_start && do_erase)
            begin
                flash_cmd_r.erase <= 1'b1;
                flash_cmd_r.addr <= {core_req.pointer[15:WI_W+1],
                                     {(WI_W+1){1'b0}}};
            end
            else if (op_start && do_lock)
            begin
                flash_cmd_r.lock_write <= 1'b1;
                flash_cmd_r.data <= core_req.word;
            end
            else if (write_phase)
            begin
                flash_cmd_r.write_word <= 1'b1;
                flash_cmd_r.addr <= wr_addr;
                flash_cmd_r.data <= valid_r[wr_idx] ? buf_mem[wr_idx] :
                                    self_prog_pkg::ERASED_WORD;
            end
        end
    end

    assign flash_cmd = flash_cmd_r;

    // Core held for the whole operation
    assign core_stall = op_busy;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence s_arm_erase;
        ctrl_wr && !op_busy && pwdata[1:0] == 2'h3;
    endsequence

    sequence s_arm_write;
        ctrl_wr && !op_busy && pwdata[2:0] == 3'h5;
    endsequence

    a_rsvd_reads_zero: assert property (
        apb_access && !pwrite && hit_ctrl |-> prdata[6:5] == 2'h0)
        else $error("reserved control bits read nonzero");

    a_erase_starts: assert property (
        s_arm_erase ##[1:4] store_go
        |=> op_state_r == ST_ERASE && flash_cmd.erase)
        else $error("erase not started by store in window");

    a_write_expires: assert property (
        s_arm_write ##1 !core_req.store_program_memory_instr[*4]
        |=> !ctrl_r[self_prog_pkg::POS_PG_WRITE] && !op_busy)
        else $error("page write bit not cleared after window");

    a_stall_covers_op: assert property (
        $rose(op_busy) |-> core_stall[*8])
        else $error("core not stalled during operation");

    a_irq_quiet_busy: assert property (
        (eeprom_write_busy || op_busy) |-> !store_ready_irq)
        else $error("store ready during busy");

    a_irq_when_idle: assert property (
        ctrl_r[7] && global_irq_enable && !ctrl_r[0] &&
        !eeprom_write_busy && !op_busy |-> store_ready_irq)
        else $error("store ready missing");

    a_ext_fuse_read: assert property (
        load_win_r != 3'h0 && core_req.load_program_memory_instr &&
        core_req.pointer == 16'h0002
        |=> lpm_rdata == $past(fuse_state.extended_fuse_byte))
        else $error("extended fuse byte not returned");

    a_buffer_cleared: assert property (
        ctrl_wr && pwdata[4] && |valid_r |=> valid_r == '0)
        else $error("page buffer not cleared");

    a_load_word: assert property (
        store_go && do_load |=> valid_r[$past(load_idx)] && !ctrl_r[0])
        else $error("buffer word not loaded");

    a_op_length: assert property (
        $fell(op_busy) |-> $past(op_cnt_r) == LAST_CYC)
        else $error("operation length wrong");

    a_reset_keeps_op: assert property (
        @(posedge mclk) disable iff (!por_ok_n)
        op_busy && !op_done |=> op_busy)
        else $error("operation aborted early");
endmodule
`default_nettype wire

/* File: shared/self_prog_pkg.sv */
// Constants, types and register map of the flash self-program controller
`default_nettype none
package self_prog_pkg;
    // Register byte offsets on the APB bus
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] MASK_OFS = 8'h08;
    // Control and status register bit positions
    localparam int POS_IRQ_EN = 7;
    localparam int POS_SECT_BUSY = 6;
    localparam int POS_RSVD = 5;
    localparam int POS_SECT_RD_EN = 4;
    localparam int POS_LOCK_SEL = 3;
    localparam int POS_PG_WRITE = 2;
    localparam int POS_PG_ERASE = 1;
    localparam int POS_SELF_EN = 0;
    // Event status bit positions
    localparam int POS_EV_DONE = 0;
    localparam int POS_EV_EXPIRE = 1;
    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] STAT_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;
    // Writable control bits
    localparam logic [7:0] CTRL_WR_MASK = 8'h9F;
    // Arming windows in clock cycles
    localparam logic [2:0] STORE_WINDOW_CYC = 3'h4;
    localparam logic [2:0] LOAD_WINDOW_CYC = 3'h3;
    // Flash operation time, timed at the least programming time
    localparam int CLK_PERIOD_NS = 25;
    localparam int PROG_MIN_NS = 3_700_000;
    localparam int PROG_MAX_NS = 4_500_000;
    localparam int PROG_CYCLES =
        (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Pointer low bits that pick a fuse or lock byte
    localparam logic [1:0] SEL_FUSE_LOW = 2'h0;
    localparam logic [1:0] SEL_LOCK = 2'h1;
    localparam logic [1:0] SEL_FUSE_EXT = 2'h2;
    localparam logic [1:0] SEL_FUSE_HIGH = 2'h3;
    // Value of a flash word that was never loaded
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;

    // Store/load instruction request from the processor core
    typedef struct packed {
        logic store_program_memory_instr;
        logic load_program_memory_instr;
        logic [15:0] pointer;
        logic [15:0] word;
    } core_req_s;

    // Nonvolatile configuration bytes, zero marks a programmed bit
    typedef struct packed {
        logic [7:0] fuse_low;
        logic [7:0] fuse_high;
        logic [7:0] extended_fuse_byte;
        logic [7:0] lock;
    } fuse_s;

    // Command to the flash array
    typedef struct packed {
        logic erase;
        logic write_word;
        logic lock_write;
        logic [15:0] addr;
        logic [15:0] data;
    } flash_cmd_s;
endpackage
`default_nettype wire

/* File: sim/core_model.sv */
// Processor core model issuing store and load program memory pulses
`timescale 1ns/10ps
`default_nettype none
module core_model
(
    input wire logic mclk,
    input wire logic core_stall,
    input wire logic [7:0] lpm_rdata,
    output var self_prog_pkg::core_req_s core_req
);
    ////////////////////////////////////////////////////////////////////
    // Idle request at time zero
    initial core_req = '0;

    // Store pulse, issued once the core is no longer stalled or after 2000 waited cycles
    task automatic store(input logic [15:0] ptr, input logic [15:0] w);
        int n;
        n = 0;
        while (core_stall !== 1'b0 && n < 2000)
        begin
            @(posedge mclk);
            n++;
        end
        core_req.pointer <= ptr;
        core_req.word <= w;
        core_req.store_program_memory_instr <= 1'b1;
        @(posedge mclk);
        core_req.store_program_memory_instr <= 1'b0;
        core_req.pointer <= ~ptr; // Operands not held after use
        core_req.word <= ~w;
    endtask

    // Load pulse, result taken two edges later
    task automatic load(input logic [15:0] ptr, output logic [7:0] q);
        core_req.pointer <= ptr;
        core_req.load_program_memory_instr <= 1'b1;
        @(posedge mclk);
        core_req.load_program_memory_instr <= 1'b0;
        core_req.pointer <= ~ptr;
        repeat (2) @(posedge mclk);
        q = lpm_rdata;
    endtask
endmodule
`default_nettype wire

/* File: sim/flash_self_program_control_tb.sv */
// Self-checking testbench of the flash self-program controller
`timescale 1ns/10ps
`default_nettype none
module flash_self_program_control_tb;
    localparam int PW = 32;
    localparam int PC = 40;
    localparam logic [7:0] ctrl_a = self_prog_pkg::CTRL_OFS;
    localparam logic [7:0] stat_a = self_prog_pkg::STAT_OFS;
    localparam logic [7:0] mask_a = self_prog_pkg::MASK_OFS;
    logic mclk, arst_n, por_n, psel, penable, pwrite, pready, pslverr;
    logic gie, ee_busy, core_stall, sr_irq, irq, err;
    logic [7:0] paddr, flash_rdata, lpm_rdata, b;
    logic [31:0] pwdata, prdata, q, seed;
    logic [15:0] p, lw;
    self_prog_pkg::core_req_s core_req;
    self_prog_pkg::fuse_s fuse;
    self_prog_pkg::flash_cmd_s flash_cmd;
    int mismatches, check_count, n;
    logic [15:0] buf_m [PW];
    logic [15:0] got_w [$];
    logic [15:0] got_e [$];
    logic [15:0] got_l [$];

    ////////////////////////////////////////////////////////////////////
    // Design and core model
    flash_self_program_control #(.PAGE_WORDS(PW), .PROG_CYCLES(PC)) dut
    (
        .mclk(mclk), .arst_n(arst_n), .por_n(por_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_req(core_req),
        .global_irq_enable(gie), .eeprom_write_busy(ee_busy),
        .fuse_state(fuse), .flash_rdata(flash_rdata),
        .lpm_rdata(lpm_rdata), .core_stall(core_stall),
        .store_ready_irq(sr_irq), .irq(irq), .flash_cmd(flash_cmd)
    );
    core_model core
    (
        .mclk(mclk), .core_stall(core_stall), .lpm_rdata(lpm_rdata),
        .core_req(core_req)
    );

    // Clock and flash command monitor
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        if (flash_cmd.write_word === 1'b1)
            got_w.push_back(flash_cmd.data);
        if (flash_cmd.erase === 1'b1)
            got_e.push_back(flash_cmd.addr);
        if (flash_cmd.lock_write === 1'b1)
            got_l.push_back(flash_cmd.data);
    end

    ////////////////////////////////////////////////////////////////////
    // Xorshift source and comparison
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string m);
        check_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("mismatch t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    // APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && k < 50)
        begin
            @(posedge mclk);
            k++;
        end
        chk(32'(k < 50), 1, "pready");
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk); // Idle cycle, no double drive of psel
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, e, "read");
    endtask
    task automatic irqchk(input logic e);
        @(posedge mclk);
        chk(32'(irq), 32'(e), "irq");
    endtask

    // Buffer word load into the model and the design
    task automatic load_word();
        logic [15:0] ptr;
        logic [15:0] w;
        ptr = 16'(rnd());
        w = 16'(rnd());
        wr(ctrl_a, 8'h81);
        core.store(ptr, w);
        buf_m[ptr[5:1]] = w;
        @(posedge mclk);
        rdchk(ctrl_a, 8'h80);
    endtask

    // Armed flash operation, optional core reset in mid-run
    task automatic op(input logic [7:0] c, input logic [15:0] ptr,
                      input logic rst);
        wr(ctrl_a, c);
        lw = 16'(rnd());
        core.store(ptr, lw);
        n = 0;
        forever
        begin
            @(posedge mclk);
            if (rst && n == 5)
                arst_n <= 1'b0;
            if (rst && n == 7)
                arst_n <= 1'b1;
            if (n == 2)
                chk(32'(sr_irq), 0, "ready irq");
            if (core_stall !== 1'b1 || n > 500)
                break;
            n++;
        end
        chk(n, PC, "stall length");
        repeat (3) @(posedge mclk);
    endtask

    // Closing verdict
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Watchdog
    initial
    begin
        #(25 * 20000);
        mismatches++;
        summarize();
    end

    // Main sequence
    initial
    begin
        {arst_n, por_n, psel, penable, pwrite, gie, ee_busy} = '0;
        {paddr, pwdata, flash_rdata} = '0;
        {mismatches, check_count} = '0;
        seed = 32'h0000_34C3;
        fuse = rnd();
        foreach (buf_m[i]) buf_m[i] = 16'hFFFF;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        por_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rdchk(ctrl_a, 8'h00);
        rdchk(stat_a, 8'h00);
        rdchk(mask_a, 8'h00);
        rdchk(8'h0C, 8'h00);
        chk(32'(err), 1, "slverr");
        wr(ctrl_a, 8'hE0);
        rdchk(ctrl_a, 8'h80);
        gie <= 1'b1;
        @(posedge mclk);
        chk(32'(sr_irq), 1, "ready irq");
        ee_busy <= 1'b1;
        @(posedge mclk);
        chk(32'(sr_irq), 0, "ready irq");
        ee_busy <= 1'b0;
        wr(mask_a, 8'h03);
        // Fill, clear, refill and write a page
        repeat (3) load_word();
        wr(ctrl_a, 8'h91);
        core.store(16'(rnd()), 16'h0000);
        foreach (buf_m[i]) buf_m[i] = 16'hFFFF;
        @(posedge mclk);
        repeat (4) load_word();
        got_w.delete();
        op(8'h85, 16'(rnd()), 1'b0);
        chk(got_w.size(), PW, "word count");
        foreach (buf_m[i]) chk(32'(got_w[i]), 32'(buf_m[i]), "word");
        foreach (buf_m[i]) buf_m[i] = 16'hFFFF;
        rdchk(ctrl_a, 8'h80);
        irqchk(1'b1);
        rdchk(stat_a, 8'h01);
        irqchk(1'b0);
        // Page erase with a core reset in mid-run
        got_e.delete();
        p = 16'(rnd());
        op(8'h83, p, 1'b1);
        chk(got_e.size(), 1, "erase count");
        chk(32'(got_e[0]), 32'({p[15:6], 6'h00}), "erase page");
        rdchk(ctrl_a, 8'h00);
        rdchk(stat_a, 8'h01);
        // Arming windows that run out, late store ignored
        for (int k = 1; k < 3; k++)
        begin
            wr(mask_a, 8'h01);
            got_w.delete();
            got_e.delete();
            wr(ctrl_a, 32'(1 + 2 * k));
            repeat (5) @(posedge mclk);
            core.store(16'(rnd()), 16'(rnd()));
            @(posedge mclk);
            chk(got_w.size() + got_e.size() + 32'(core_stall), 0, "late");
            rdchk(ctrl_a, 8'h00);
            irqchk(1'b0);
            wr(mask_a, 8'h03);
            irqchk(1'b1);
            rdchk(stat_a, 8'h02);
            irqchk(1'b0);
        end
        // Lock byte write through an armed store
        got_l.delete();
        op(8'h89, 16'(rnd()), 1'b0);
        chk(got_l.size(), 1, "lock count");
        chk(32'(got_l[0]), 32'(lw), "lock data");
        // Fuse and lock reads, then plain and late loads
        for (int s = 0; s < 4; s++)
        begin
            fuse <= rnd();
            wr(ctrl_a, 8'h09);
            core.load((s == 2) ? 16'h0002 : 16'(rnd()) & 16'hFFFC | 16'(s),
                      b);
            q = (s == 0) ? fuse.fuse_low : (s == 1) ? fuse.lock :
                (s == 2) ? fuse.extended_fuse_byte : fuse.fuse_high;
            chk(32'(b), q, "fuse");
            repeat (4) @(posedge mclk);
        end
        flash_rdata <= 8'(rnd());
        core.load(16'(rnd()), b);
        chk(32'(b), 32'(flash_rdata), "flash");
        wr(ctrl_a, 8'h09);
        repeat (4) @(posedge mclk);
        core.load(16'h0002, b);
        chk(32'(b), 32'(flash_rdata), "late load");
        summarize();
    end
endmodule
`default_nettype wire
